// ---- rtl/ssl_consts.svh ----
`ifndef SSL_CONSTS_SVH
`define SSL_CONSTS_SVH

// -----------------------------------------------------------------------------
// widths and depths
// -----------------------------------------------------------------------------
`define SSL_WIDTH      16
`define SSL_LAST_BIT   15
`define SSL_BUF_DEPTH  2

// -----------------------------------------------------------------------------
// reset values of control state and buffer count levels
// -----------------------------------------------------------------------------
`define SSL_SYNC_RST   3'h0
`define SSL_SYNC_IDLE_HI 3'h7
`define SSL_FILT_RST   5'h01
`define SSL_CNT_RST    2'h0
`define SSL_CNT_FULL   2'h2
`define SSL_CNT_ONE    2'h1

`endif

// ---- rtl/ssl_pkg.sv ----
`default_nettype none

package ssl_pkg;

	// -------------------------------------------------------------------------
	// shift register modes
	// -------------------------------------------------------------------------
	typedef enum logic [1:0] {
		SSL_HOLD,
		SSL_SHIFT,
		SSL_RELOAD
	} ssl_mode_e;

	typedef logic [15:0] ssl_word_t;

	// mode seen by the shift register at a shift clock fall
	function automatic ssl_mode_e ssl_decode(input logic cs_b, input logic dir, input logic store);
		ssl_mode_e m;
		m = SSL_HOLD;
		if (cs_b) begin
			m = SSL_HOLD;
		end else if (dir && store) begin
			m = SSL_RELOAD;
		end else begin
			m = SSL_SHIFT;
		end
		return m;
	endfunction : ssl_decode

endpackage : ssl_pkg

`default_nettype wire

// ---- rtl/ssl_shift_latch.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ssl_consts.svh"

// How it works
// RULE1: sixteen stage shifter, mode from select/direction/store
// RULE2: shifter changes only on shift clock fall
// RULE3: shift: serial in to first stage, last out
// RULE4: reload: storage copied in parallel, no shift
// RULE5: decode hold, shift, shift, reload per levels
// RULE6: storage holds while select or direction high
// RULE7: storage captures shifter on store clock rise
// RULE8: select active low, store acts rising edge
// RULE9: controller keeps shift clock low raising select
// RULE10: controller keeps store clock low when enabling
// RULE11: parallel outputs show storage register only
// RULE12: data registers have no reset
module ssl_shift_latch
	import ssl_pkg::*;
(
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	// controller pins
	input  wire logic                  cs_b_i,
	input  wire logic                  dir_i,
	input  wire logic                  shift_clk_i,
	input  wire logic                  store_clk_i,
	input  wire logic                  serial_i,
	// pin outputs
	output logic                       serial_o,
	output logic [`SSL_LAST_BIT:0]     parallel_out_o,
	// captured word stream
	output logic [`SSL_LAST_BIT:0]     capt_data_o,
	output logic                       capt_valid_o,
	input  wire logic                  capt_ready_i,
	output logic                       capt_ready_o
);

	// -------------------------------------------------------------------------
	// pin filters
	// -------------------------------------------------------------------------
	// three stages per pin; a level counts once stages two and three agree,
	// which also rejects a single-cycle glitch on a clock pin
	localparam int NPIN = 5;

	logic [2:0]      sync_r [NPIN];
	logic [2:0]      sync_nxt [NPIN];
	logic [NPIN-1:0] filt_r;
	logic [NPIN-1:0] filt_nxt;
	logic [NPIN-1:0] pins;

	assign pins = {serial_i, store_clk_i, shift_clk_i, dir_i, cs_b_i};

	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			sync_nxt[i] = {sync_r[i][1:0], pins[i]};
			filt_nxt[i] = (sync_r[i][2] == sync_r[i][1]) ? sync_r[i][2] : filt_r[i];
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 1; i < NPIN; i++) begin
				sync_r[i] <= `SSL_SYNC_RST;
			end
			// select idles high; a zero here would read as selected after reset
			sync_r[0] <= `SSL_SYNC_IDLE_HI;
			filt_r    <= `SSL_FILT_RST;
		end else begin
			sync_r <= sync_nxt;
			filt_r <= filt_nxt;
		end
	end

	// filtered levels; select is active low
	logic cs_b_f;
	logic dir_f;
	logic shclk_f;
	logic stclk_f;
	logic ser_f;

	assign cs_b_f  = filt_r[0]; // see RULE8
	assign dir_f   = filt_r[1];
	assign shclk_f = filt_r[2];
	assign stclk_f = filt_r[3];
	assign ser_f   = filt_r[4];

	// -------------------------------------------------------------------------
	// edge events
	// -------------------------------------------------------------------------
	logic shift_fall;
	logic store_rise;

	assign shift_fall = shclk_f && !filt_nxt[2];  // see RULE2
	assign store_rise = !stclk_f && filt_nxt[3];  // see RULE8

	// mode levels sampled together with the edge that acts on them
	ssl_mode_e mode;
	logic      store_cap;

	assign mode      = ssl_decode(cs_b_f, dir_f, stclk_f);       // see RULE5
	assign store_cap = store_rise && !cs_b_f && !dir_f;          // see RULE6

	// -------------------------------------------------------------------------
	// shift and storage registers
	// -------------------------------------------------------------------------
	ssl_word_t shift_r;
	ssl_word_t shift_nxt;
	ssl_word_t store_r;
	ssl_word_t store_nxt;

	always_comb begin
		shift_nxt = shift_r;
		if (shift_fall) begin                                      // see RULE2
			case (mode)
				SSL_SHIFT:  shift_nxt = {shift_r[14:0], ser_f};      // see RULE3
				SSL_RELOAD: shift_nxt = store_r;                     // see RULE4
				default:    shift_nxt = shift_r;                     // see RULE1
			endcase
		end
		store_nxt = store_cap ? shift_r : store_r;                 // see RULE7
	end

	// no reset: contents stay unknown until loaded
	always_ff @(posedge clk_i) begin                               // see RULE12
		shift_r <= shift_nxt;
		store_r <= store_nxt;
	end

	assign serial_o       = shift_r[`SSL_LAST_BIT];                // see RULE3
	assign parallel_out_o = store_r;                               // see RULE11

	// -------------------------------------------------------------------------
	// two-entry capture buffer
	// -------------------------------------------------------------------------
	// the pins cannot be stalled; capt_ready_o tells the controller to hold
	// off store pulses, a capture made while it is low is not queued
	ssl_word_t ent0_r;
	ssl_word_t ent0_nxt;
	ssl_word_t ent1_r;
	ssl_word_t ent1_nxt;
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic       vld_r;
	logic       vld_nxt;
	logic       rdy_r;
	logic       rdy_nxt;
	logic       push;
	logic       pop;

	assign push = store_cap && rdy_r;
	assign pop  = vld_r && capt_ready_i;

	always_comb begin
		ent0_nxt = ent0_r;
		ent1_nxt = ent1_r;
		cnt_nxt  = cnt_r;
		if (push && pop) begin
			if (cnt_r == `SSL_CNT_ONE) begin
				ent0_nxt = shift_r;
			end else begin
				ent0_nxt = ent1_r;
				ent1_nxt = shift_r;
			end
		end else if (push) begin
			if (cnt_r == `SSL_CNT_RST) begin
				ent0_nxt = shift_r;
			end else begin
				ent1_nxt = shift_r;
			end
			cnt_nxt = cnt_r + `SSL_CNT_ONE;
		end else if (pop) begin
			ent0_nxt = ent1_r;
			cnt_nxt  = cnt_r - `SSL_CNT_ONE;
		end
		vld_nxt = (cnt_nxt != `SSL_CNT_RST);
		rdy_nxt = (cnt_nxt != `SSL_CNT_FULL);
	end

	always_ff @(posedge clk_i) begin
		ent0_r <= ent0_nxt;
		ent1_r <= ent1_nxt;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r <= `SSL_CNT_RST;
			vld_r <= 1'b0;
			rdy_r <= 1'b1;
		end else begin
			cnt_r <= cnt_nxt;
			vld_r <= vld_nxt;
			rdy_r <= rdy_nxt;
		end
	end

	assign capt_data_o  = ent0_r;
	assign capt_valid_o = vld_r;
	assign capt_ready_o = rdy_r;

	// -------------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------------
	AST_SHIFT_ONLY_ON_FALL: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE2
		!shift_fall |=> $stable(shift_r))
		else $error("shift register changed without a shift clock fall");

	AST_FALL_CAUSE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE2
		shift_fall |-> !$past(shift_clk_i, 2) && !$past(shift_clk_i, 3) && $past(shclk_f))
		else $error("shift clock fall seen without a settled low level");

	AST_SHIFT_MOVE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE3
		shift_fall && !cs_b_f && !(dir_f && stclk_f)
		|=> shift_r === {$past(shift_r[14:0]), $past(ser_f)})
		else $error("shift mode did not move serial data in");

	AST_RELOAD: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE4
		shift_fall && !cs_b_f && dir_f && stclk_f |=> shift_r === $past(store_r))
		else $error("reload mode did not copy storage");

	AST_CS_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE5
		cs_b_f |=> $stable(shift_r) && $stable(store_r))
		else $error("registers changed while deselected");

	AST_STORE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE6
		cs_b_f || dir_f || !store_rise |=> $stable(store_r))
		else $error("storage changed outside a capture");

	AST_STORE_CAP: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE7
		store_rise && !cs_b_f && !dir_f |=> parallel_out_o == $past(shift_r))
		else $error("store clock rise did not capture the shifter");

	AST_RISE_CAUSE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE8
		store_rise |-> $past(store_clk_i, 2) && $past(store_clk_i, 3) && !$past(stclk_f))
		else $error("store rise seen without a settled high level");

	AST_BUF_PUSH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		store_cap && capt_ready_o |=> capt_valid_o)
		else $error("captured word not offered");

	AST_BUF_STALL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		capt_valid_o && !capt_ready_i |=> capt_valid_o && $stable(capt_data_o))
		else $error("stalled word changed or vanished");

	AST_BUF_FULL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cnt_r == `SSL_CNT_FULL |-> !capt_ready_o && capt_valid_o)
		else $error("full buffer still ready");

	AST_BUF_POP_LAST: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		capt_valid_o && capt_ready_i && !store_cap && cnt_r == `SSL_CNT_ONE |=> !capt_valid_o)
		else $error("last word popped but still offered");

	AST_BUF_FREE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		capt_valid_o && capt_ready_i |=> capt_ready_o)
		else $error("pop did not free a buffer entry");

	// decode checked against the mode table itself, not the function
	AST_MODE_DESEL: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE5
		cs_b_f |-> mode == SSL_HOLD)
		else $error("deselected mode is not hold");

	AST_MODE_DIR_LOW: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE5
		!cs_b_f && !dir_f |-> mode == SSL_SHIFT)
		else $error("direction low mode is not shift");

	AST_MODE_STORE_LOW: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE5
		!cs_b_f && dir_f && !stclk_f |-> mode == SSL_SHIFT)
		else $error("direction high, store low mode is not shift");

	AST_MODE_RELOAD: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE5
		!cs_b_f && dir_f && stclk_f |-> mode == SSL_RELOAD)
		else $error("direction high, store high mode is not reload");

	AST_SER_FOLLOW: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE3
		shift_fall && mode == SSL_SHIFT |=> serial_o === $past(shift_r[14]))
		else $error("serial output did not advance by one stage");

	AST_FALL_SETTLES: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE2
		shift_fall |=> !shclk_f)
		else $error("shift clock fall not followed by a low level");

	AST_RISE_SETTLES: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE8
		store_rise |=> stclk_f)
		else $error("store clock rise not followed by a high level");

	AST_DIR_NO_STORE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE6
		store_rise && dir_f |=> $stable(parallel_out_o))
		else $error("store rise with direction high changed outputs");

	AST_DESEL_NO_STORE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE6
		store_rise && cs_b_f |=> $stable(parallel_out_o))
		else $error("store rise while deselected changed outputs");

	AST_RELOAD_KEEPS_OUT: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE4
		shift_fall && mode == SSL_RELOAD |=> $stable(parallel_out_o))
		else $error("reload disturbed the parallel outputs");

	AST_OUT_ONLY_STORE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // see RULE11
		!store_cap |=> $stable(parallel_out_o))
		else $error("parallel outputs moved without a capture");

endmodule : ssl_shift_latch

`default_nettype wire

// ---- test/ssl_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------------------
// controller driving the device pins
// -----------------------------------------------------------------------------
module ssl_ctrl_model (
	// clock
	input  wire logic clk_i,
	// pins toward the device
	output var logic  cs_b_o,
	output var logic  dir_o,
	output var logic  shift_clk_o,
	output var logic  store_clk_o,
	output var logic  serial_o
);
	initial begin
		cs_b_o      = 1'b1;
		dir_o       = 1'b0;
		shift_clk_o = 1'b0;
		store_clk_o = 1'b0;
		serial_o    = 1'b0;
	end

	// pin filter needs four stable cycles, five leaves margin
	task automatic step;
		repeat (5) @(posedge clk_i);
	endtask : step

	// select and direction move only while both clocks are low
	task automatic frame(input logic cs_b, input logic dir);
		cs_b_o <= cs_b;
		dir_o  <= dir;
		step();
	endtask : frame

	// one shift clock pulse; store level set up before the fall
	task automatic sclk(input logic si, input logic st);
		serial_o    <= si;
		store_clk_o <= st;
		step();
		shift_clk_o <= 1'b1;
		step();
		shift_clk_o <= 1'b0;
		step();
		store_clk_o <= 1'b0;
		serial_o    <= ~si;
		step();
	endtask : sclk

	task automatic stclk;
		store_clk_o <= 1'b1;
		step();
		store_clk_o <= 1'b0;
		step();
	endtask : stclk
endmodule : ssl_ctrl_model

`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
	$display("ERROR %0t: got %h exp %h", $time, a, e); end end

module tb;
	import ssl_pkg::*;

	logic      clk_i = 1'b0;
	logic      rst_b_i = 1'b0;
	logic      capt_ready_i = 1'b0;
	logic      cs_b, dir, sck, stk, si, so, cap_v, cap_r;
	ssl_word_t po, cap_d, sh_m, st_m, w;
	ssl_word_t q[$];
	int        num_errors = 0;
	int        checks = 0;
	int        known = 0;

	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	ssl_ctrl_model ctrl (.clk_i(clk_i), .cs_b_o(cs_b), .dir_o(dir), .shift_clk_o(sck),
		.store_clk_o(stk), .serial_o(si));

	ssl_shift_latch DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .dir_i(dir),
		.shift_clk_i(sck), .store_clk_i(stk), .serial_i(si), .serial_o(so),
		.parallel_out_o(po), .capt_data_o(cap_d), .capt_valid_o(cap_v),
		.capt_ready_i(capt_ready_i), .capt_ready_o(cap_r));

	// -------------------------------------------------------------------------
	// expectation helpers
	// -------------------------------------------------------------------------
	function automatic ssl_word_t shl(input ssl_word_t v, input logic b);
		return {v[14:0], b};
	endfunction : shl

	task automatic sbit(input logic b);
		ctrl.sclk(b, 1'b0);
		sh_m = shl(sh_m, b);
		known++;
		if (known >= 16) `CHK(so, sh_m[15])
	endtask : sbit

	task automatic sword(input ssl_word_t v);
		for (int i = 15; i >= 0; i--) sbit(v[i]);
	endtask : sword

	task automatic store;
		ctrl.stclk();
		st_m = sh_m;
		`CHK(po, st_m)
	endtask : store

	task automatic results;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : results

	initial begin
		#(25 * 20000);
		num_errors++;
		results();
	end

	// -------------------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------------------
	initial begin
		void'($urandom(29));
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		ctrl.frame(1'b0, 1'b0);
		// sink stalled: third capture finds the buffer full
		for (int k = 0; k < 3; k++) begin
			w = 16'($urandom);
			sword(w);
			store();
			if (k < 2) q.push_back(w);
		end
		`CHK(cap_r, 1'b0)
		`CHK(cap_v, 1'b1)
		@(posedge clk_i);
		capt_ready_i <= 1'b1;
		#1 `CHK(cap_d, q[0])
		@(posedge clk_i);
		#1 `CHK(cap_d, q[1])
		@(posedge clk_i);
		#1 `CHK(cap_v, 1'b0)
		// sink stalled again so that a wrong capture stays visible
		@(posedge clk_i);
		capt_ready_i <= 1'b0;
		// one more bit makes the shifter differ from storage
		sbit(~sh_m[15]);
		// deselected: both clocks ignored
		ctrl.frame(1'b1, 1'b0);
		ctrl.sclk(~sh_m[15], 1'b0);
		ctrl.stclk();
		`CHK(so, sh_m[15])
		`CHK(po, st_m)
		`CHK(cap_v, 1'b0)
		// direction high: store rise refused, shifting still works
		ctrl.frame(1'b0, 1'b1);
		ctrl.stclk();
		`CHK(po, st_m)
		`CHK(cap_v, 1'b0)
		w = 16'($urandom);
		sword(w);
		`CHK(po, st_m)
		// reload, then shift the stored word out
		ctrl.sclk(~st_m[15], 1'b1);
		sh_m = st_m;
		`CHK(so, sh_m[15])
		for (int i = 0; i < 15; i++) sbit(1'($urandom));
		// direction low with store high: capture, then shift
		ctrl.frame(1'b0, 1'b0);
		w[0] = 1'($urandom);
		st_m = sh_m;
		ctrl.sclk(w[0], 1'b1);
		sh_m = shl(sh_m, w[0]);
		`CHK(so, sh_m[15])
		`CHK(po, st_m)
		`CHK(cap_v, 1'b1)
		`CHK(cap_d, st_m)
		ctrl.frame(1'b1, 1'b0);
		results();
	end
endmodule : tb

`default_nettype wire
